// ---- design/asr_pkg.sv ----
// Constants shared by the serial audio receive port and its link side.
// Assumes an 8-bit register port on the core clock.
`default_nettype none

package asr_pkg;
    // ========================================================
    // Register offsets, reset values, writable bits
    localparam logic [7:0] ADDR_FORMAT  = 8'h13;
    localparam logic [7:0] ADDR_ROUTE   = 8'h14;
    localparam logic [7:0] ADDR_PULL    = 8'h15;
    localparam logic [7:0] ADDR_RATE    = 8'h19;
    localparam logic [7:0] RST_FORMAT   = 8'h0A;
    localparam logic [7:0] RST_ROUTE    = 8'h00;
    localparam logic [7:0] RST_PULL     = 8'h00;
    localparam logic [7:0] RST_RATE     = 8'h12;
    localparam logic [7:0] WMASK_FORMAT = 8'h7F;
    localparam logic [7:0] WMASK_ROUTE  = 8'hFF;
    localparam logic [7:0] WMASK_PULL   = 8'h07;
    localparam logic [7:0] WMASK_RATE   = 8'hDF;
    // ========================================================
    // Field positions
    localparam int BIT_INVERT  = 6;
    localparam int BIT_ROLE    = 5;
    localparam int BIT_POL     = 4;
    localparam int LSB_WL      = 2;
    localparam int LSB_FMT     = 0;
    localparam int LSB_ROUTING = 6;
    localparam int BIT_TRI     = 3;
    localparam int BIT_PD_DATA = 2;
    localparam int BIT_PD_FRM  = 1;
    localparam int BIT_PD_BCK  = 0;
    localparam int LSB_OVR     = 6;
    // ========================================================
    // Codes
    typedef enum logic [1:0] {
        ASR_FMT_RJ = 2'b00, ASR_FMT_LJ = 2'b01,
        ASR_FMT_I2S = 2'b10, ASR_FMT_RSVD = 2'b11
    } asr_fmt_type;
    typedef enum logic [1:0] {
        ASR_RT_STRAIGHT = 2'b00, ASR_RT_LEFT = 2'b01,
        ASR_RT_RIGHT = 2'b10, ASR_RT_SWAP = 2'b11
    } asr_route_type;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] BITS_32 = 6'h20;

    // Word length code to bit count
    function automatic logic [5:0] asr_wl_bits(input logic [1:0] code);
        case (code)
            2'b00:   return BITS_16;
            2'b01:   return BITS_20;
            2'b10:   return BITS_24;
            default: return BITS_32;
        endcase
    endfunction
endpackage

`default_nettype wire

// ---- design/asr_rx_if.sv ----
// Carrier between core-side registers and the link-side shifter.
// Assumes config is quasi-static and pairs change once per frame.
`default_nettype none

interface asr_rx_if;
    logic [4:0]  cfg;        // {polarity, word length, format}
    logic [31:0] pair_left;
    logic [31:0] pair_right;
    logic        pair_toggle;
    modport core (output cfg, input pair_left, pair_right, pair_toggle);
    modport rx   (input cfg, output pair_left, pair_right, pair_toggle);
endinterface

`default_nettype wire

// ---- design/asr_rx_shift.sv ----
// Link-side shifter: samples data and frame clock on the bit clock.
// Assumes i_link_clk is the (possibly inverted) bit clock pin.
`default_nettype none

module asr_rx_shift (
    input  wire logic i_link_clk,
    input  wire logic i_rst_n,
    input  wire logic i_serial_data_in,
    input  wire logic i_frame_clock,
    asr_rx_if.rx      rx
);
    // ========================================================
    // Reset and config crossing, two flops each
    logic       rst_meta, rst_sync;
    logic [4:0] cfg_meta, cfg_sync;
    logic       lr_prev, toggle;
    logic [5:0] idx, cnt;
    logic [31:0] acc, left_hold;

    always_ff @(posedge i_link_clk) begin
        rst_meta <= i_rst_n;
        rst_sync <= rst_meta;
        cfg_meta <= rx.cfg;
        cfg_sync <= cfg_meta;
    end

    // Result left-aligned; missing low bits come out as zeros
    function automatic logic [31:0] align(input logic [31:0] a,
                                          input logic [5:0]  n);
        logic [31:0] m;
        m = (n >= asr_pkg::BITS_32) ? 32'hFFFF_FFFF
            : ((32'h0000_0001 << n) - 32'h0000_0001);
        return (n == 6'h00) ? 32'h0000_0000
            : ((a & m) << (asr_pkg::BITS_32 - n));
    endfunction

    // ========================================================
    // Slot decode
    wire logic [1:0] fmt    = cfg_sync[1:0];
    wire logic [5:0] wl     = asr_pkg::asr_wl_bits(cfg_sync[3:2]);
    wire logic       lr     = i_frame_clock ^ cfg_sync[4]; // R04
    wire logic       edge_n = lr != lr_prev;
    wire logic       is_rj  = fmt == asr_pkg::ASR_FMT_RJ;
    wire logic [5:0] start  = (fmt == asr_pkg::ASR_FMT_I2S) ? 6'h01
                                                            : 6'h00;
    wire logic [5:0] cur_idx = edge_n ? 6'h00
                             : (idx == 6'h3F ? idx : idx + 6'h01);
    wire logic [5:0] cur_cnt = edge_n ? 6'h00 : cnt;
    // R01 R17: skip one slot for I2S; R19: stop after the word
    wire logic take = is_rj || (cur_idx >= start && cur_cnt < wl);
    wire logic [31:0] acc_base = edge_n ? 32'h0000_0000 : acc;
    // R18: right-justified keeps the last wl bits before the edge
    wire logic [5:0] next_cnt = !take ? cur_cnt
                              : (cur_cnt >= wl ? wl : cur_cnt + 6'h01);
    wire logic [31:0] word  = align(acc, cnt);

    // Shift and hand finished pairs over
    always_ff @(posedge i_link_clk) begin
        if (!rst_sync) begin
            lr_prev <= 1'b0;
            idx <= 6'h00;
            cnt <= 6'h00;
            acc <= 32'h0000_0000;
            left_hold <= 32'h0000_0000;
            rx.pair_left <= 32'h0000_0000;
            rx.pair_right <= 32'h0000_0000;
            toggle <= 1'b0;
        end else begin
            lr_prev <= lr;
            idx <= cur_idx;
            cnt <= next_cnt;
            acc <= take ? {acc_base[30:0], i_serial_data_in} : acc_base;
            if (edge_n && lr_prev) begin
                left_hold <= word; // R17 high frame clock is left
            end
            if (edge_n && !lr_prev) begin
                rx.pair_left <= left_hold;
                rx.pair_right <= word;
                toggle <= ~toggle;
            end
        end
    end
    assign rx.pair_toggle = toggle;

    i2s_skip_a: assert property (@(posedge i_link_clk) // R01
        disable iff (!rst_sync)
        edge_n && fmt == asr_pkg::ASR_FMT_I2S |=> cnt == 6'h00)
        else $error("I2S took a bit in the first slot");
    word_cap_a: assert property (@(posedge i_link_clk) // R19
        disable iff (!rst_sync)
        !is_rj && edge_n ##1 !edge_n [*3] |-> cnt <= 6'h03)
        else $error("bit count ran past received slots");
endmodule

`default_nettype wire

// ---- design/asr_port.sv ----
// Serial audio receive port: registers, clock master, routing.
// Assumes the register port is driven on i_core_clk and that pins
// feed back through the bench as the wire levels.
//
// Behaviour
// R01: I2S: MSB on second rising bit clock after frame edge.
// R02: Register bit 6 inverts the bit clock in either role.
// R03: Bit 5 picks master when 1, slave when 0; resets 0.
// R04: Bit 4 inverts frame clock polarity for all formats.
// R05: Bits 3:2 word length 16/20/24/32, reset 24.
// R06: Bits 1:0 format RJ/LJ/I2S, 11 reserved, reset I2S.
// R07: Tristate bit makes clock pins high impedance.
// R08: Slave role makes every interface pin an input.
// R09: Undriven pins get their pull-down unless disabled.
// R10: Routing field sends channels to the two DACs.
// R11: Data pin pull-down on when 0, off when 1.
// R12: Frame and bit clock pull-downs on as inputs unless disabled.
// R13: Auto master rate follows word length; 24 bits give 64 per frame.
// R14: Nonzero override field replaces automatic bit clock rate.
// R15: Override gives 16, 20 or 32 bit clocks per channel.
// R16: Master bit clock runs evenly and continuously across frame.
// R17: LJ: MSB on first rising edge; high frame clock means left.
// R18: RJ: LSB on last rising edge before frame edge.
// R19: Extra received bits ignored; missing low bits zero.
// R20: Master makes both clocks; slave follows received clocks.
// R21: Clock pair mode field stored and read back only.
`default_nettype none

module asr_port #(
    parameter int unsigned HALF_BIT_CYCLES = 4
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_we,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic        i_serial_data_in,
    output logic             o_data_pulldown_en,
    input  wire logic        i_bit_clock_pin_i,
    output logic             o_bit_clock_pin_o,
    output logic             o_bit_clock_pin_oe,
    output logic             o_bit_clock_pulldown_en,
    input  wire logic        i_frame_clock_pin_i,
    output logic             o_frame_clock_pin_o,
    output logic             o_frame_clock_pin_oe,
    output logic             o_frame_clock_pulldown_en,
    output logic      [31:0] o_dac_left,
    output logic      [31:0] o_dac_right,
    output logic             o_dac_valid
);
    // ========================================================
    // Elaboration check
    generate
        if (HALF_BIT_CYCLES < 1 || HALF_BIT_CYCLES > 65535) begin : g_chk
            $error("HALF_BIT_CYCLES must be 1 to 65535");
        end
    endgenerate

    localparam logic [15:0] HALF_LAST = 16'(HALF_BIT_CYCLES - 1);

    // ========================================================
    // Registers
    logic [7:0] audio_format_control;
    logic [7:0] interface_routing_tristate;
    logic [7:0] pin_pulldown_control;
    logic [7:0] sample_rate_bitclock_control;

    wire logic wr_fmt  = i_reg_we && i_reg_addr == asr_pkg::ADDR_FORMAT;
    wire logic wr_rt   = i_reg_we && i_reg_addr == asr_pkg::ADDR_ROUTE;
    wire logic wr_pull = i_reg_we && i_reg_addr == asr_pkg::ADDR_PULL;
    wire logic wr_rate = i_reg_we && i_reg_addr == asr_pkg::ADDR_RATE;

    // Reserved read-only bits are masked off on write, so read zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            audio_format_control <= asr_pkg::RST_FORMAT; // R03 R05 R06
            interface_routing_tristate <= asr_pkg::RST_ROUTE;
            pin_pulldown_control <= asr_pkg::RST_PULL;
            sample_rate_bitclock_control <= asr_pkg::RST_RATE;
        end else begin
            if (wr_fmt) begin
                audio_format_control <=
                    i_reg_wdata & asr_pkg::WMASK_FORMAT;
            end
            if (wr_rt) begin
                interface_routing_tristate <= // R21
                    i_reg_wdata & asr_pkg::WMASK_ROUTE;
            end
            if (wr_pull) begin
                pin_pulldown_control <= i_reg_wdata & asr_pkg::WMASK_PULL;
            end
            if (wr_rate) begin
                sample_rate_bitclock_control <=
                    i_reg_wdata & asr_pkg::WMASK_RATE;
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    wire logic [7:0] next_rdata =
        (i_reg_addr == asr_pkg::ADDR_FORMAT) ? audio_format_control
      : (i_reg_addr == asr_pkg::ADDR_ROUTE)  ? interface_routing_tristate
      : (i_reg_addr == asr_pkg::ADDR_PULL)   ? pin_pulldown_control
      : (i_reg_addr == asr_pkg::ADDR_RATE)
            ? sample_rate_bitclock_control
      : 8'h00;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= next_rdata;
        end
    end

    // ========================================================
    // Field decode
    wire logic bit_clock_invert =
        audio_format_control[asr_pkg::BIT_INVERT];
    wire logic role_select = audio_format_control[asr_pkg::BIT_ROLE];
    wire logic frame_clock_polarity =
        audio_format_control[asr_pkg::BIT_POL];
    wire logic [1:0] word_length_sel =
        audio_format_control[asr_pkg::LSB_WL +: 2];
    wire logic [1:0] channel_routing =
        interface_routing_tristate[asr_pkg::LSB_ROUTING +: 2];
    wire logic pins_tristate =
        interface_routing_tristate[asr_pkg::BIT_TRI];
    wire logic data_pin_pulldown_off =
        pin_pulldown_control[asr_pkg::BIT_PD_DATA];
    wire logic frame_clock_pulldown_off =
        pin_pulldown_control[asr_pkg::BIT_PD_FRM];
    wire logic bit_clock_pulldown_off =
        pin_pulldown_control[asr_pkg::BIT_PD_BCK];
    wire logic [1:0] bit_clock_override =
        sample_rate_bitclock_control[asr_pkg::LSB_OVR +: 2];
    // R07 R08: clock pins driven only as master with tristate clear
    wire logic drive_clocks = role_select && !pins_tristate;

    // ========================================================
    // Master bit clock rate per channel
    // Auto: 16-bit words fit 16 clocks, wider words take 32 (64 fs)
    wire logic [5:0] auto_bits =
        (word_length_sel == 2'b00) ? asr_pkg::BITS_16   // R13
                                   : asr_pkg::BITS_32;
    wire logic [5:0] ovr_bits =
        (bit_clock_override == 2'b01) ? asr_pkg::BITS_16  // R15
      : (bit_clock_override == 2'b10) ? asr_pkg::BITS_20
      : asr_pkg::BITS_32;
    wire logic [5:0] bits_per_ch =
        (bit_clock_override == 2'b00) ? auto_bits : ovr_bits; // R14
    wire logic [5:0] bits_last = bits_per_ch - 6'h01;

    // ========================================================
    // Master clock generator; frame edge lands on a falling bit clock
    // edge so every frame holds a whole number of even bit periods.
    logic [15:0] half_cnt;
    logic        gen_bclk;
    logic        gen_lr;
    logic [5:0]  bit_cnt;

    wire logic half_done = half_cnt == HALF_LAST;
    wire logic bclk_fall = half_done && gen_bclk;
    wire logic ch_done   = bclk_fall && bit_cnt == bits_last;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || !role_select) begin
            half_cnt <= 16'h0000;
            gen_bclk <= 1'b0;
            gen_lr <= 1'b1;
            bit_cnt <= 6'h00;
        end else if (half_done) begin // R16 R20
            half_cnt <= 16'h0000;
            gen_bclk <= ~gen_bclk;
            if (ch_done) begin
                bit_cnt <= 6'h00;
                gen_lr <= ~gen_lr;
            end else if (bclk_fall) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end else begin
            half_cnt <= half_cnt + 16'h0001;
        end
    end

    // ========================================================
    // Pin drivers and pull-downs, all registered
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_bit_clock_pin_o <= 1'b0;
            o_frame_clock_pin_o <= 1'b0;
            o_bit_clock_pin_oe <= 1'b0;
            o_frame_clock_pin_oe <= 1'b0;
            o_data_pulldown_en <= 1'b1;
            o_bit_clock_pulldown_en <= 1'b1;
            o_frame_clock_pulldown_en <= 1'b1;
        end else begin
            o_bit_clock_pin_o <= gen_bclk ^ bit_clock_invert; // R02
            o_frame_clock_pin_o <= gen_lr ^ frame_clock_polarity; // R04
            o_bit_clock_pin_oe <= drive_clocks; // R07 R08
            o_frame_clock_pin_oe <= drive_clocks; // R07 R08
            o_data_pulldown_en <= !data_pin_pulldown_off; // R11
            o_bit_clock_pulldown_en <= // R09 R12
                !drive_clocks && !bit_clock_pulldown_off;
            o_frame_clock_pulldown_en <= // R09 R12
                !drive_clocks && !frame_clock_pulldown_off;
        end
    end

    // ========================================================
    // Link side; inversion flips the sampling edge. Change the invert
    // bit only while idle: the gate can make a runt clock edge.
    asr_rx_if rx_bus ();
    wire logic link_clk = i_bit_clock_pin_i ^ bit_clock_invert; // R02

    assign rx_bus.cfg = {frame_clock_polarity, word_length_sel,
                         audio_format_control[asr_pkg::LSB_FMT +: 2]};

    asr_rx_shift u_rx (
        .i_link_clk       (link_clk),
        .i_rst_n          (i_rst_n),
        .i_serial_data_in (i_serial_data_in),
        .i_frame_clock    (i_frame_clock_pin_i), // R20
        .rx               (rx_bus.rx)
    );

    // ========================================================
    // Pair arrival crossing: toggle through two flops, then edge
    logic tog_meta, tog_sync, tog_seen;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= rx_bus.pair_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    // Pair words are stable long after the toggle, so plain capture
    wire logic pair_new = tog_sync != tog_seen;

    // Channel routing to the two DACs
    function automatic logic [31:0] pick(input logic [1:0]  route,
                                         input logic        right_dac,
                                         input logic [31:0] l,
                                         input logic [31:0] r);
        case (route)
            asr_pkg::ASR_RT_STRAIGHT: return right_dac ? r : l;
            asr_pkg::ASR_RT_LEFT:     return l;
            asr_pkg::ASR_RT_RIGHT:    return r;
            default:                  return right_dac ? l : r;
        endcase
    endfunction

    wire logic [31:0] next_left = pick(channel_routing, 1'b0,
        rx_bus.pair_left, rx_bus.pair_right); // R10
    wire logic [31:0] next_right = pick(channel_routing, 1'b1,
        rx_bus.pair_left, rx_bus.pair_right); // R10

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_dac_left <= 32'h0000_0000;
            o_dac_right <= 32'h0000_0000;
            o_dac_valid <= 1'b0;
        end else begin
            o_dac_valid <= pair_new;
            if (pair_new) begin
                o_dac_left <= next_left;
                o_dac_right <= next_right;
            end
        end
    end

    // ========================================================
    // Checks
    slave_inputs_a: assert property (@(posedge i_core_clk) // R08
        disable iff (!i_rst_n)
        !role_select |=> !o_bit_clock_pin_oe && !o_frame_clock_pin_oe)
        else $error("slave drove a clock pin");
    tristate_pins_a: assert property (@(posedge i_core_clk) // R07
        disable iff (!i_rst_n)
        role_select && pins_tristate ##1 pins_tristate
            |-> !o_bit_clock_pin_oe
                && !o_frame_clock_pin_oe
                && o_bit_clock_pulldown_en != $past(bit_clock_pulldown_off))
        else $error("tristated clock pin still driven");
    master_drive_a: assert property (@(posedge i_core_clk) // R20
        disable iff (!i_rst_n)
        drive_clocks [*2] |-> o_bit_clock_pin_oe && o_frame_clock_pin_oe)
        else $error("master not driving clocks");
    pull_bclk_a: assert property (@(posedge i_core_clk) // R12
        disable iff (!i_rst_n)
        (!drive_clocks && !bit_clock_pulldown_off) [*2]
            |-> o_bit_clock_pulldown_en && !o_bit_clock_pin_oe)
        else $error("input bit clock pin lacks pull-down");
    pull_data_a: assert property (@(posedge i_core_clk) // R11
        disable iff (!i_rst_n)
        $rose(data_pin_pulldown_off) |=> !o_data_pulldown_en)
        else $error("data pull-down not disabled");
    frame_even_a: assert property (@(posedge i_core_clk) // R16
        disable iff (!i_rst_n)
        role_select && $changed(gen_lr) |-> $fell(gen_bclk)
            && $past(bit_cnt) == $past(bits_last))
        else $error("frame edge off the bit grid");
    rate_64fs_a: assert property (@(posedge i_core_clk) // R13
        disable iff (!i_rst_n)
        word_length_sel == 2'b10 && bit_clock_override == 2'b00
            |-> bits_per_ch == asr_pkg::BITS_32)
        else $error("24-bit auto not 64 clocks per frame");
    route_swap_a: assert property (@(posedge i_core_clk) // R10
        disable iff (!i_rst_n)
        pair_new && channel_routing == 2'b11
            |=> o_dac_left == $past(rx_bus.pair_right)
                && o_dac_right == $past(rx_bus.pair_left))
        else $error("swap routing wrong");
    fmt_reset_a: assert property (@(posedge i_core_clk) // R05
        disable iff (!i_rst_n)
        $past(i_rst_n) == 1'b0 |-> audio_format_control == 8'h0A)
        else $error("format register reset value wrong");
    // Pull-downs follow the pin direction and the disable bits
    pull_frame_a: assert property (@(posedge i_core_clk) // R09
        disable iff (!i_rst_n)
        (!drive_clocks && !frame_clock_pulldown_off) [*2]
            |-> o_frame_clock_pulldown_en && !o_frame_clock_pin_oe)
        else $error("frame clock pin lacks pull-down");
    pull_off_a: assert property (@(posedge i_core_clk) // R12
        disable iff (!i_rst_n)
        bit_clock_pulldown_off && frame_clock_pulldown_off
            |=> !o_bit_clock_pulldown_en && !o_frame_clock_pulldown_en)
        else $error("clock pull-down not disabled");
    // Register hold, reserved format code and idle generator
    route_hold_a: assert property (@(posedge i_core_clk) // R21
        disable iff (!i_rst_n)
        !wr_rt |=> $stable(interface_routing_tristate))
        else $error("routing register changed unwritten");
    fmt_code_a: assert property (@(posedge i_core_clk) // R06
        disable iff (!i_rst_n)
        wr_fmt && i_reg_wdata[1:0] == 2'b11
            |=> audio_format_control[1:0] == 2'b11)
        else $error("reserved format code not stored");
    slave_idle_a: assert property (@(posedge i_core_clk) // R20
        disable iff (!i_rst_n)
        !role_select |=> !gen_bclk && bit_cnt == 6'h00)
        else $error("slave ran the clock generator");
endmodule

`default_nettype wire

// ---- test/asr_src.sv ----
// Audio source model: bit clock, frame clock and serial data.
// Assumes the port samples data on the rising bit clock edge.
`default_nettype none
module asr_src (
    output var logic o_bclk,
    output var logic o_frame,
    output var logic o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Bursts of bit clock, still between calls
    initial begin
        o_bclk = 0;
        o_frame = 0;
        o_data = 0;
    end
    // Data changes after the falling edge, 32 ns period
    task automatic tick(input logic d);
        o_data = d;
        #16 o_bclk = 1;
        #16 o_bclk = 0;
    endtask
    // Clocks only, so the link side can take its reset
    task automatic burst(input int n);
        repeat (n) tick(~o_data);
    endtask
    // One stereo pair of 24-bit words, 32 clocks per channel
    task automatic send(input logic [1:0] fmt, input logic [31:0] l, r);
        int o;
        int b;
        logic [31:0] w;
        o = (fmt == 2'b10) ? 1 : (fmt == 2'b01) ? 0 : 8;
        for (int c = 0; c < 2; c++) begin
            o_frame = (c == 0);
            w = (c == 0) ? l : r;
            for (int k = 0; k < 32; k++) begin
                b = k - o;
                // Unused slots toggle so stale bits never look valid
                tick((b >= 0 && b < 24) ? w[31 - b] : ~o_data);
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- test/tb_audio_serial_rx_port.sv ----
// Bench for the serial audio receive port with a source model.
// Assumes asr_pkg, asr_rx_if, asr_rx_shift and asr_port compiled.
`default_nettype none
module tb_audio_serial_rx_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;
    logic        dpd, bo, boe, bpd, fo, foe, fpd, dv;
    logic [31:0] dl, dr, l, r;
    logic [63:0] e;
    logic [63:0] q[$];
    logic        sb, sf, sd, armed;
    int          fails, n_compared, seed;
    // Wire level: the port when it drives, else the source
    wire logic   bpin = boe ? bo : sb;
    wire logic   fpin = foe ? fo : sf;
    asr_port #(.HALF_BIT_CYCLES(2)) uut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_we(we), .o_reg_rdata(rdata),
        .i_serial_data_in(sd), .o_data_pulldown_en(dpd),
        .i_bit_clock_pin_i(bpin), .o_bit_clock_pin_o(bo),
        .o_bit_clock_pin_oe(boe), .o_bit_clock_pulldown_en(bpd),
        .i_frame_clock_pin_i(fpin), .o_frame_clock_pin_o(fo),
        .o_frame_clock_pin_oe(foe), .o_frame_clock_pulldown_en(fpd),
        .o_dac_left(dl), .o_dac_right(dr), .o_dac_valid(dv));
    asr_src src (.o_bclk(sb), .o_frame(sf), .o_data(sd));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, exp, input string s);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1;
        @(posedge clk);
        we <= 0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 check(rdata, exp, "rdata");
    endtask
    // Half frame length and bit clocks in it, master role
    task automatic meas(input int bits);
        int n;
        int nb;
        logic v;
        logic pb;
        repeat (2) @(fo);
        v = fo;
        pb = bo;
        nb = 0;
        for (n = 1; n < 999; n++) begin
            @(posedge clk);
            #1;
            if (bo && !pb) nb++;
            pb = bo;
            if (fo !== v) break;
        end
        check(n, bits * 4, "half frame");
        check(nb, bits, "bit clocks");
    endtask
    // Only the middle pair is checked; outer pairs absorb the change
    task automatic rx(input logic [1:0] fmt, rt);
        wr(8'h13, {6'h02, fmt});
        wr(8'h14, {rt, 6'h00});
        l = $random(seed) & 32'hFFFF_FF00;
        r = $random(seed) & 32'hFFFF_FF00;
        q.push_back({rt[1] ? r : l, rt[0] ? l : r});
        src.send(fmt, ~l, ~r);
        src.send(fmt, l, r);
        armed = 1;
        src.send(fmt, ~l, ~r);
        repeat (20) @(posedge clk);
        armed = 0;
    endtask
    // ==========================================================
    // Clock, monitor, watchdog
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Each pulse takes the oldest expected pair
    always @(posedge clk) begin
        if (dv === 1'b1 && armed) begin
            if (q.size() == 0)
                check(dv, 0, "dac_valid");
            else begin
                e = q.pop_front();
                check(dl, e[63:32], "dac_left");
                check(dr, e[31:0], "dac_right");
            end
        end
    end
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 0;
        addr = 0;
        wdata = 0;
        we = 0;
        armed = 0;
        seed = 32'h9fd4_a99b;
        src.burst(4);
        repeat (4) @(posedge clk);
        rst_n <= 1;
        rd(8'h13, 8'h0A);
        rd(8'h14, 8'h00);
        rd(8'h19, 8'h12);
        rd(8'h20, 8'h00);
        check({dpd, bpd, fpd, boe, foe}, 5'h1C, "pins");
        wr(8'h15, 8'hFF);
        rd(8'h15, 8'h07);
        check({dpd, bpd, fpd}, 3'h0, "pulldowns");
        wr(8'h15, 8'h00);
        wr(8'h13, 8'hFF);
        rd(8'h13, 8'h7F);
        rx(2'b10, 2'b00);
        rx(2'b10, 2'b01);
        rx(2'b01, 2'b10);
        rx(2'b00, 2'b11);
        wr(8'h13, 8'h2A);
        rd(8'h13, 8'h2A);
        check({boe, foe, bpd, fpd}, 4'hC, "master pins");
        meas(32);
        for (int c = 1; c < 4; c++) begin
            wr(8'h19, {c[1:0], 6'h12});
            meas(c == 1 ? 16 : c == 2 ? 20 : 32);
        end
        wr(8'h14, 8'h08);
        repeat (3) @(posedge clk);
        check({boe, foe, bpd, fpd}, 4'h3, "tristate");
        check(q.size(), 0, "queue");
        complete_run();
    end
endmodule
`default_nettype wire
